/* src/cmp_core_state.sv */
// Core mode, privilege, stack pointer and special register state.
//
// Operation
// - Core starts in thread mode after reset.
// - Handler mode returns to thread once no exception remains active.
// - Handler mode always runs privileged.
// - Control word writes take effect only from privileged code.
// - Unprivileged code denied system peripherals and the interrupt-mask-change instruction.
// - Push decrements active pointer first, then stores at new address.
// - Handler mode always uses the main stack pointer.
// - In thread mode stack-select bit 1 picks main (0) or process (1).
// - Reset loads main stack pointer from word at address zero.
// - Reset loads instruction pointer from the word at address four.
// - Reset vector bit 0 loads execution-state bit 24; memory supplies 1.
// - Condition flags N Z C V sit at bits 31..28, rest zero.
// - Exception number bits 5:0 report the current exception.
// - Writes to exception-number bits are ignored through every view.
// - Execution-state bits read zero and ignore writes by move instructions.
// - Only exchange branches, pop-to-pointer, return restore and vector clear T.
// - Executing with execution-state bit zero raises a severe fault.
// - Interrupt abandons multi-cycle instruction; it restarts from its beginning.
// - Priority mask bit 0 set blocks activation of configurable exceptions.
// - Control bit 0 sets thread privilege: 0 privileged, 1 unprivileged.
// - In handler mode stack-select reads zero and ignores writes.
// - Hardware updates control word on exception entry and return.
`timescale 1ns/1ns
module cmp_core_state (
    input  wire logic                 core_clk,
    input  wire logic                 rst_b,
    input  wire logic                 clk_en,
    output logic                      boot_req,
    output logic [31:0]               boot_addr,
    input  wire logic                 boot_ack,
    input  wire logic [31:0]          boot_rdata,
    input  wire cmp_pkg::cmp_sr_req_type sr_req,
    output logic [31:0]               sr_rdata,
    output logic                      sr_rvalid,
    input  wire cmp_pkg::cmp_exc_type exc_evt,
    input  wire logic                 flags_we,
    input  wire logic [3:0]           flags_in,
    input  wire logic                 push_req,
    input  wire logic [31:0]          push_data,
    input  wire logic                 pop_req,
    output logic                      stk_wr_valid,
    output logic [31:0]               stk_wr_addr,
    output logic [31:0]               stk_wr_data,
    input  wire cmp_pkg::cmp_tsrc_type t_src,
    input  wire logic                 t_val,
    input  wire logic                 pc_load,
    input  wire logic [31:0]          pc_in,
    input  wire logic                 instr_issue,
    input  wire logic                 instr_start,
    input  wire logic                 multi_busy,
    input  wire logic                 irq_take,
    input  wire logic                 cfg_exc_pend,
    input  wire logic                 cps_req,
    input  wire logic                 cps_val,
    input  wire logic                 sys_periph_req,
    output logic                      boot_done,
    output logic                      handler_mode,
    output logic                      privileged,
    output logic                      proc_sp_active,
    output logic [31:0]               active_sp,
    output logic [31:0]               instruction_pointer,
    output logic                      t_bit,
    output logic                      severe_fault,
    output logic                      abandon,
    output logic [31:0]               restart_pc,
    output logic                      cfg_exc_activate,
    output logic                      periph_denied,
    output logic                      cps_denied
);
    import cmp_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    cmp_state_type state_reg;
    logic [31:0]   main_sp_reg;
    logic [31:0]   proc_sp_reg;
    logic [31:0]   pc_reg;
    logic [3:0]    flags_reg;
    logic [5:0]    exc_num_reg;
    logic          t_reg;
    logic          gmask_reg;
    logic [1:0]    ctrl_reg;
    logic [31:0]   restart_reg;
    logic [31:0]   rdata_reg;
    logic          rvalid_reg;
    logic          swr_valid_reg;
    logic [31:0]   swr_addr_reg;
    logic [31:0]   swr_data_reg;
    logic          fault_reg;
    logic [31:0]   sp_next;
    logic [31:0]   rd_next;
    logic          in_handler;
    logic          is_priv;
    logic          use_proc;
    logic          sel_flags;
    logic          sel_exc;
    logic          run;

    assign run          = clk_en && (state_reg == ST_RUN);
    assign in_handler   = (exc_num_reg != EXC_THREAD);
    assign is_priv      = in_handler || !ctrl_reg[THREAD_UNPRIVILEGED_BIT_POS];
    assign use_proc     = !in_handler && ctrl_reg[STACK_CHOICE_BIT_POS];
    assign active_sp    = use_proc ? proc_sp_reg : main_sp_reg;

    assign handler_mode        = in_handler;
    assign privileged          = is_priv;
    assign proc_sp_active      = use_proc;
    assign instruction_pointer = pc_reg;
    assign t_bit               = t_reg;
    assign boot_done           = (state_reg == ST_RUN);
    assign boot_req            = clk_en && !boot_done;
    assign sr_rdata            = rdata_reg;
    assign sr_rvalid           = rvalid_reg;
    assign stk_wr_valid        = swr_valid_reg;
    assign stk_wr_addr         = swr_addr_reg;
    assign stk_wr_data         = swr_data_reg;
    assign severe_fault        = fault_reg;
    assign restart_pc          = restart_reg;
    assign abandon             = run && irq_take && multi_busy;
    assign cfg_exc_activate    = run && cfg_exc_pend && !gmask_reg;
    assign periph_denied       = sys_periph_req && !is_priv;
    assign cps_denied          = cps_req && !is_priv;

    assign sel_flags = (sr_req.sel == SEL_FLAGS) || (sr_req.sel == SEL_FLAGS_EXC)
                    || (sr_req.sel == SEL_FLAGS_EXEC) || (sr_req.sel == SEL_ALL);
    assign sel_exc   = (sr_req.sel == SEL_FLAGS_EXC) || (sr_req.sel == SEL_ALL)
                    || (sr_req.sel == SEL_EXC) || (sr_req.sel == SEL_EXC_EXEC);

    ////////////////////////////////////////////////////////////////////////
    // Reset fetch sequence: stack pointer word, then reset vector word.
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            state_reg <= ST_BOOT_SP;
            boot_addr <= BOOT_SP_ADDR;
        end else if (clk_en && boot_ack) begin
            unique case (state_reg)
                ST_BOOT_SP: begin
                    state_reg <= ST_BOOT_PC;
                    boot_addr <= BOOT_PC_ADDR;
                end
                ST_BOOT_PC: state_reg <= ST_RUN;
                ST_RUN:     state_reg <= ST_RUN;
                default: begin
                    state_reg <= ST_BOOT_SP;
                    boot_addr <= BOOT_SP_ADDR;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Exception number and mode.
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            exc_num_reg <= EXC_RST;
        end else if (run) begin
            if (exc_evt.entry || exc_evt.ret) begin
                exc_num_reg <= exc_evt.num;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control word.
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            ctrl_reg <= CTRL_RST;
        end else if (run) begin
            if (exc_evt.entry) begin
                ctrl_reg[STACK_CHOICE_BIT_POS] <= 1'h0;
            end else if (exc_evt.ret) begin
                ctrl_reg[STACK_CHOICE_BIT_POS] <= (exc_evt.num == EXC_THREAD) && exc_evt.ret_stack_choice_bit;
            end else if (sr_req.wr && (sr_req.sel == SEL_CTRL) && is_priv) begin
                ctrl_reg[THREAD_UNPRIVILEGED_BIT_POS] <= sr_req.wdata[THREAD_UNPRIVILEGED_BIT_POS];
                if (!in_handler) begin
                    ctrl_reg[STACK_CHOICE_BIT_POS] <= sr_req.wdata[STACK_CHOICE_BIT_POS];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Priority mask, by move instruction or mask-change instruction.
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            gmask_reg <= GMASK_RST;
        end else if (run && is_priv) begin
            if (cps_req) begin
                gmask_reg <= cps_val;
            end else if (sr_req.wr && (sr_req.sel == SEL_GMASK)) begin
                gmask_reg <= sr_req.wdata[PM_POS];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Condition flags.
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            flags_reg <= FLAGS_RST;
        end else if (run) begin
            if (sr_req.wr && sel_flags) begin
                flags_reg <= sr_req.wdata[FLAGS_MSB:FLAGS_LSB];
            end else if (flags_we) begin
                flags_reg <= flags_in;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Execution-state bit.
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            t_reg <= 1'h0;
        end else if (clk_en) begin
            if (state_reg == ST_BOOT_PC && boot_ack) begin
                t_reg <= boot_rdata[VEC_T_POS];
            end else if (run && t_src != TSRC_NONE) begin
                t_reg <= t_val;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            fault_reg <= 1'h0;
        end else if (clk_en) begin
            fault_reg <= run && instr_issue && !t_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Instruction pointer and restart point.
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            pc_reg <= 32'h0000_0000;
        end else if (clk_en) begin
            if (state_reg == ST_BOOT_PC && boot_ack) begin
                pc_reg <= {boot_rdata[31:1], 1'h0};
            end else if (run && abandon) begin
                pc_reg <= restart_reg;
            end else if (run && pc_load) begin
                pc_reg <= pc_in;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            restart_reg <= 32'h0000_0000;
        end else if (run && instr_start) begin
            restart_reg <= pc_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Stack pointers.
    // decrement then store
    always_comb begin
        sp_next = active_sp;
        if (push_req) begin
            sp_next = active_sp - SP_STEP;
        end else if (pop_req) begin
            sp_next = active_sp + SP_STEP;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            main_sp_reg <= 32'h0000_0000;
            proc_sp_reg <= 32'h0000_0000;
        end else if (clk_en) begin
            if (state_reg == ST_BOOT_SP && boot_ack) begin
                main_sp_reg <= {boot_rdata[31:2], 2'h0};
            end else if (run && (push_req || pop_req)) begin
                if (use_proc) begin
                    proc_sp_reg <= sp_next;
                end else begin
                    main_sp_reg <= sp_next;
                end
            end else if (run && sr_req.wr && sr_req.sel == SEL_MAIN_SP && is_priv) begin
                main_sp_reg <= {sr_req.wdata[31:2], 2'h0};
            end else if (run && sr_req.wr && sr_req.sel == SEL_PROC_SP && is_priv) begin
                proc_sp_reg <= {sr_req.wdata[31:2], 2'h0};
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            swr_valid_reg <= 1'h0;
            swr_addr_reg  <= 32'h0000_0000;
            swr_data_reg  <= 32'h0000_0000;
        end else if (clk_en) begin
            swr_valid_reg <= run && push_req;
            if (run && push_req) begin
                swr_addr_reg <= sp_next;
                swr_data_reg <= push_data;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Special-register read data.
    always_comb begin
        rd_next = 32'h0000_0000;
        unique case (sr_req.sel)
            SEL_MAIN_SP: rd_next = main_sp_reg;
            SEL_PROC_SP: rd_next = proc_sp_reg;
            SEL_GMASK:   rd_next[PM_POS] = gmask_reg;
            SEL_CTRL: begin
                rd_next[THREAD_UNPRIVILEGED_BIT_POS] = ctrl_reg[THREAD_UNPRIVILEGED_BIT_POS];
                rd_next[STACK_CHOICE_BIT_POS] = ctrl_reg[STACK_CHOICE_BIT_POS] && !in_handler;
            end
            default: begin
                if (sel_flags) begin
                    rd_next[FLAGS_MSB:FLAGS_LSB] = flags_reg;
                end
                if (sel_exc) begin
                    rd_next[EXC_MSB:0] = exc_num_reg;
                end
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            rdata_reg  <= 32'h0000_0000;
            rvalid_reg <= 1'h0;
        end else if (clk_en) begin
            rvalid_reg <= run && sr_req.rd;
            if (run && sr_req.rd) begin
                rdata_reg <= rd_next;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks.
    handler_priv_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        handler_mode |-> privileged)
        else $error("handler mode not privileged");
    handler_msp_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        handler_mode |-> (!proc_sp_active && active_sp == main_sp_reg))
        else $error("handler mode not on main stack");
    unpriv_ctrl_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        (run && !privileged && sr_req.wr && sr_req.sel == SEL_CTRL && !exc_evt.entry && !exc_evt.ret)
        |=> $stable(ctrl_reg))
        else $error("unprivileged control write took effect");
    push_order_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        (run && push_req) |=> (stk_wr_valid && stk_wr_addr == active_sp
        && stk_wr_addr == $past(active_sp) - 32'h0000_0004))
        else $error("push address not decremented pointer");
    exc_write_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        (run && sr_req.wr && sel_exc && !exc_evt.entry && !exc_evt.ret) |=> $stable(exc_num_reg))
        else $error("exception number changed by write");
    exec_read_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        sr_rvalid |-> (sr_rdata[EXEC_T_POS] == 1'h0 || $past(sr_req.sel == SEL_MAIN_SP)
        || $past(sr_req.sel == SEL_PROC_SP)))
        else $error("execution bit visible on read");
    t_fault_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        (run && instr_issue && !t_bit) |=> severe_fault)
        else $error("no fault with execution bit clear");
    mask_gate_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        cfg_exc_activate |-> !gmask_reg)
        else $error("activation while masked");
    boot_thread_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        (clk_en && state_reg == ST_BOOT_PC && boot_ack) |=> (boot_done && !handler_mode))
        else $error("not in thread mode after reset fetch");
    boot_t_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        (clk_en && state_reg == ST_BOOT_PC && boot_ack) |=> (t_bit == $past(boot_rdata[0])))
        else $error("execution bit not from reset vector");
endmodule

/* src/cmp_pkg.sv */
// Constants and types shared by the core mode, privilege and stack state block.
package cmp_pkg;

    // Reset fetch addresses and stack pointer step.
    localparam logic [31:0] BOOT_SP_ADDR = 32'h0000_0000;
    localparam logic [31:0] BOOT_PC_ADDR = 32'h0000_0004;
    localparam logic [31:0] SP_STEP      = 32'h0000_0004;

    // Field positions.
    localparam int FLAGS_MSB  = 31;
    localparam int FLAGS_LSB  = 28;
    localparam int EXC_MSB    = 5;
    localparam int EXEC_T_POS = 24;
    localparam int STACK_CHOICE_BIT_POS  = 1;
    localparam int THREAD_UNPRIVILEGED_BIT_POS  = 0;
    localparam int PM_POS     = 0;
    localparam int VEC_T_POS  = 0;

    // Reset values.
    localparam logic [5:0] EXC_RST   = 6'h00;
    localparam logic       GMASK_RST = 1'h0;
    localparam logic [1:0] CTRL_RST  = 2'h0;
    localparam logic [3:0] FLAGS_RST = 4'h0;

    // Exception numbers.
    localparam logic [5:0] EXC_THREAD    = 6'h00;
    localparam logic [5:0] EXC_NMI       = 6'h02;
    localparam logic [5:0] EXC_FAULT     = 6'h03;
    localparam logic [5:0] EXC_SVC       = 6'h0B;
    localparam logic [5:0] EXC_PENDED    = 6'h0E;
    localparam logic [5:0] EXC_TICK      = 6'h0F;
    localparam logic [5:0] EXC_EXT_FIRST = 6'h10;
    localparam logic [5:0] EXC_EXT_LAST  = 6'h2F;

    // Special-register selectors for the move instructions.
    typedef enum logic [3:0] {
        SEL_FLAGS      = 4'h0,
        SEL_FLAGS_EXC  = 4'h1,
        SEL_FLAGS_EXEC = 4'h2,
        SEL_ALL        = 4'h3,
        SEL_EXC        = 4'h5,
        SEL_EXEC       = 4'h6,
        SEL_EXC_EXEC   = 4'h7,
        SEL_MAIN_SP    = 4'h8,
        SEL_PROC_SP    = 4'h9,
        SEL_GMASK      = 4'hA,
        SEL_CTRL       = 4'hB
    } cmp_sel_type;

    // Sources allowed to load the execution-state bit.
    typedef enum logic [2:0] {
        TSRC_NONE     = 3'h0,
        TSRC_BR_EXCH  = 3'h1,
        TSRC_BRL_EXCH = 3'h2,
        TSRC_POP_PC   = 3'h3,
        TSRC_EXC_RET  = 3'h4,
        TSRC_EXC_VEC  = 3'h5
    } cmp_tsrc_type;

    typedef enum logic [1:0] {
        ST_BOOT_SP = 2'h0,
        ST_BOOT_PC = 2'h1,
        ST_RUN     = 2'h2
    } cmp_state_type;

    typedef struct packed {
        logic        rd;
        logic        wr;
        cmp_sel_type sel;
        logic [31:0] wdata;
    } cmp_sr_req_type;

    typedef struct packed {
        logic       entry;
        logic       ret;
        logic [5:0] num;
        logic       ret_stack_choice_bit;
    } cmp_exc_type;

endpackage

/* verif/tb.sv */
// Self-checking bench for the core mode, privilege and stack state block.
`timescale 1ns/1ns
module tb;
    import cmp_pkg::*;
    typedef struct packed {
        logic        wr;
        cmp_sel_type sel;
        logic [31:0] wdata;
        logic [31:0] exp;
    } cmp_row_type;
    logic           core_clk = 1'b0;
    logic           rst_b = 1'b0;
    logic           boot_ack = 1'b0, flags_we = 1'b0, push_req = 1'b0, pop_req = 1'b0, t_val = 1'b1;
    logic           pc_load = 1'b0, instr_issue = 1'b0, instr_start = 1'b0, multi_busy = 1'b0;
    logic           irq_take = 1'b0, cfg_exc_pend = 1'b0, cps_req = 1'b0, cps_val = 1'b0;
    logic           sys_periph_req = 1'b0, clk_en = 1'b1;
    logic [3:0]     flags_in = 4'h0;
    logic [31:0]    boot_rdata = 32'h0, push_data = 32'h0, pc_in = 32'h0;
    cmp_sr_req_type sr_req = '0;
    cmp_exc_type    exc_evt = '0;
    cmp_tsrc_type   t_src = TSRC_NONE;
    logic           boot_req, sr_rvalid, stk_wr_valid, boot_done, handler_mode, privileged, proc_sp_active;
    logic           t_bit, severe_fault, abandon, cfg_exc_activate, periph_denied, cps_denied;
    logic [31:0]    boot_addr, sr_rdata, stk_wr_addr, stk_wr_data, active_sp, instruction_pointer, restart_pc;
    int             n_fail = 0;
    int             checks = 0;
    cmp_row_type    rows [8];

    always #10 core_clk = ~core_clk;

    cmp_core_state cmp_core_state_inst (
        .core_clk(core_clk), .rst_b(rst_b), .clk_en(clk_en), .boot_req(boot_req), .boot_addr(boot_addr),
        .boot_ack(boot_ack), .boot_rdata(boot_rdata), .sr_req(sr_req), .sr_rdata(sr_rdata),
        .sr_rvalid(sr_rvalid), .exc_evt(exc_evt), .flags_we(flags_we), .flags_in(flags_in),
        .push_req(push_req), .push_data(push_data), .pop_req(pop_req), .stk_wr_valid(stk_wr_valid),
        .stk_wr_addr(stk_wr_addr), .stk_wr_data(stk_wr_data), .t_src(t_src), .t_val(t_val),
        .pc_load(pc_load), .pc_in(pc_in), .instr_issue(instr_issue), .instr_start(instr_start),
        .multi_busy(multi_busy), .irq_take(irq_take), .cfg_exc_pend(cfg_exc_pend), .cps_req(cps_req),
        .cps_val(cps_val), .sys_periph_req(sys_periph_req), .boot_done(boot_done),
        .handler_mode(handler_mode), .privileged(privileged), .proc_sp_active(proc_sp_active),
        .active_sp(active_sp), .instruction_pointer(instruction_pointer), .t_bit(t_bit),
        .severe_fault(severe_fault), .abandon(abandon), .restart_pc(restart_pc),
        .cfg_exc_activate(cfg_exc_activate), .periph_denied(periph_denied), .cps_denied(cps_denied)
    );

    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk32(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic chk1(input string name, input logic exp, input logic got);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %b seen %b", name, exp, got);
        end
    endtask

    // One move request; a read also checks the answer one cycle later.
    task automatic sr(input logic wr, input cmp_sel_type sel, input logic [31:0] d, input logic [31:0] exp);
        @(posedge core_clk);
        sr_req <= '{rd: !wr, wr: wr, sel: sel, wdata: d};
        @(posedge core_clk);
        sr_req <= '0;
        if (!wr) begin
            @(negedge core_clk);
            chk1("sr_rvalid", 1'b1, sr_rvalid);
            chk32("sr_rdata", exp, sr_rdata);
        end
    endtask

    task automatic exc(input logic e, input logic r, input logic [5:0] n, input logic s);
        @(posedge core_clk);
        exc_evt <= '{entry: e, ret: r, num: n, ret_stack_choice_bit: s};
        @(posedge core_clk);
        exc_evt <= '0;
        @(negedge core_clk);
    endtask

    initial begin
        repeat (5000) @(posedge core_clk);
        n_fail++;
        finish_test();
    end

    initial begin
        rows = '{'{1'b1, SEL_FLAGS, 32'hFFFF_FFFF, 32'hF000_0000}, '{1'b1, SEL_ALL, 32'h5100_002F, 32'h5000_0000},
                 '{1'b0, SEL_EXC_EXEC, 32'h0, 32'h0}, '{1'b1, SEL_GMASK, 32'hFFFF_FFFF, 32'h1},
                 '{1'b1, SEL_CTRL, 32'hFFFF_FFFE, 32'h2}, '{1'b1, SEL_PROC_SP, 32'h3000_0000, 32'h3000_0000},
                 '{1'b0, SEL_MAIN_SP, 32'h0, 32'h2000_0100}, '{1'b1, SEL_EXC, 32'h5, 32'h0}};
        repeat (8) @(posedge core_clk);
        rst_b <= 1'b1;
        @(negedge core_clk);
        chk1("handler_mode", 1'b0, handler_mode);
        chk1("privileged", 1'b1, privileged);
        chk32("boot_addr", BOOT_SP_ADDR, boot_addr);
        chk1("boot_req", 1'b1, boot_req);
        @(posedge core_clk);
        boot_ack <= 1'b1;
        boot_rdata <= 32'h2000_0103;
        @(posedge core_clk);
        boot_rdata <= 32'h0000_0201;
        @(negedge core_clk);
        chk32("boot_addr", BOOT_PC_ADDR, boot_addr);
        @(posedge core_clk);
        boot_ack <= 1'b0;
        @(negedge core_clk);
        chk1("boot_done", 1'b1, boot_done);
        chk32("main_sp", 32'h2000_0100, active_sp);
        chk32("ip", 32'h0000_0200, instruction_pointer);
        chk1("t_bit", 1'b1, t_bit);
        chk1("boot_req", 1'b0, boot_req);
        foreach (rows[i]) begin
            if (rows[i].wr) begin
                sr(1'b1, rows[i].sel, rows[i].wdata, 32'h0);
            end
            sr(1'b0, rows[i].sel, 32'h0, rows[i].exp);
        end
        chk32("active_sp", 32'h3000_0000, active_sp);
        @(posedge core_clk);
        cfg_exc_pend <= 1'b1;
        @(negedge core_clk);
        chk1("cfg_exc_activate", 1'b0, cfg_exc_activate);
        @(posedge core_clk);
        push_req <= 1'b1;
        push_data <= 32'hDEAD_BEEF;
        @(posedge core_clk);
        push_req <= 1'b0;
        @(negedge core_clk);
        chk1("stk_wr_valid", 1'b1, stk_wr_valid);
        chk32("stk_wr_addr", 32'h2FFF_FFFC, stk_wr_addr);
        chk32("stk_wr_data", 32'hDEAD_BEEF, stk_wr_data);
        chk32("active_sp", 32'h2FFF_FFFC, active_sp);
        @(posedge core_clk);
        pop_req <= 1'b1;
        flags_we <= 1'b1;
        flags_in <= 4'hA;
        @(posedge core_clk);
        pop_req <= 1'b0;
        flags_we <= 1'b0;
        @(negedge core_clk);
        chk32("active_sp", 32'h3000_0000, active_sp);
        sr(1'b0, SEL_FLAGS, 32'h0, 32'hA000_0000);
        exc(1'b1, 1'b0, EXC_TICK, 1'b0);
        chk1("handler_mode", 1'b1, handler_mode);
        chk1("proc_sp_active", 1'b0, proc_sp_active);
        chk32("active_sp", 32'h2000_0100, active_sp);
        sr(1'b0, SEL_EXC, 32'h0, 32'h0000_000F);
        sr(1'b1, SEL_CTRL, 32'h2, 32'h0);
        sr(1'b0, SEL_CTRL, 32'h0, 32'h0);
        sr(1'b1, SEL_GMASK, 32'h0, 32'h0);
        @(negedge core_clk);
        chk1("cfg_exc_activate", 1'b1, cfg_exc_activate);
        exc(1'b0, 1'b1, EXC_THREAD, 1'b1);
        chk1("handler_mode", 1'b0, handler_mode);
        chk1("proc_sp_active", 1'b1, proc_sp_active);
        sr(1'b1, SEL_CTRL, 32'h3, 32'h0);
        @(negedge core_clk);
        chk1("privileged", 1'b0, privileged);
        sr(1'b1, SEL_CTRL, 32'h0, 32'h0);
        sr(1'b0, SEL_CTRL, 32'h0, 32'h3);
        @(posedge core_clk);
        cps_req <= 1'b1;
        cps_val <= 1'b1;
        sys_periph_req <= 1'b1;
        @(negedge core_clk);
        chk1("cps_denied", 1'b1, cps_denied);
        chk1("periph_denied", 1'b1, periph_denied);
        @(posedge core_clk);
        cps_req <= 1'b0;
        sys_periph_req <= 1'b0;
        sr(1'b0, SEL_GMASK, 32'h0, 32'h0);
        exc(1'b1, 1'b0, EXC_EXT_FIRST, 1'b0);
        chk1("privileged", 1'b1, privileged);
        @(posedge core_clk);
        t_src <= TSRC_BR_EXCH;
        t_val <= 1'b0;
        pc_load <= 1'b1;
        pc_in <= 32'h0000_0400;
        @(posedge core_clk);
        t_src <= TSRC_NONE;
        pc_in <= 32'h0000_0408;
        instr_issue <= 1'b1;
        instr_start <= 1'b1;
        @(posedge core_clk);
        instr_issue <= 1'b0;
        instr_start <= 1'b0;
        pc_load <= 1'b0;
        @(negedge core_clk);
        chk1("t_bit", 1'b0, t_bit);
        chk1("severe_fault", 1'b1, severe_fault);
        @(posedge core_clk);
        multi_busy <= 1'b1;
        irq_take <= 1'b1;
        @(negedge core_clk);
        chk1("abandon", 1'b1, abandon);
        chk32("ip", 32'h0000_0408, instruction_pointer);
        @(posedge core_clk);
        multi_busy <= 1'b0;
        irq_take <= 1'b0;
        @(negedge core_clk);
        chk32("restart_pc", 32'h0000_0400, restart_pc);
        chk32("ip", 32'h0000_0400, instruction_pointer);
        // A push offered while the clock enable is low must leave stk_wr_valid low and the active stack pointer unchanged.
        @(posedge core_clk);
        clk_en <= 1'b0;
        push_req <= 1'b1;
        @(posedge core_clk);
        clk_en <= 1'b1;
        push_req <= 1'b0;
        @(negedge core_clk);
        chk1("stk_wr_valid", 1'b0, stk_wr_valid);
        chk32("active_sp", 32'h2000_0100, active_sp);
        finish_test();
    end
endmodule
